// *** verilog/fcc_pkg.sv ***
// constants and types shared by the fan commutation control block
package fcc_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // cycles covering a time in ns, rounded up, never below one
  function automatic int unsigned cyc_from_ns(input longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    return (c == 0) ? 32'd1 : 32'(c);
  endfunction

  // standby delay, lock window and lock off time
  localparam longint unsigned STANDBY_NS  = 400_000;
  localparam longint unsigned LOCK_ON_NS  = 500_000_000;
  localparam longint unsigned LOCK_OFF_NS = 64'd4_500_000_000;
  localparam int unsigned STANDBY_CYC  = cyc_from_ns(STANDBY_NS);
  localparam int unsigned LOCK_ON_CYC  = cyc_from_ns(LOCK_ON_NS);
  localparam int unsigned LOCK_OFF_CYC = cyc_from_ns(LOCK_OFF_NS);

  // triangle: set for 36 kHz, runs near 39 kHz, 255 steps up and 255 down per period
  localparam int unsigned TRI_HZ    = 36_000;
  localparam int unsigned TRI_STEPS = 256;
  localparam int unsigned TRI_DIV   = CLK_HZ / (TRI_HZ * 2 * TRI_STEPS);
  localparam int unsigned DIV_W     = 4;
  localparam logic [DIV_W-1:0] TRI_DIV_LAST = DIV_W'(TRI_DIV - 1);

  localparam int unsigned CODE_W = 8;
  localparam logic [CODE_W-1:0] TRI_TOP = 8'hff;
  localparam logic [CODE_W-1:0] TRI_BOT = 8'h00;
  localparam int unsigned SBY_W = 16;
  localparam int unsigned LCK_W = 28;

  typedef enum logic [1:0] {
    FCC_LK_RUN   = 2'b00,
    FCC_LK_OFF   = 2'b01,
    FCC_LK_RETRY = 2'b10
  } fcc_lock_st_t;

endpackage

// *** verilog/fcc_link_if.sv ***
// internal signals between the top and its triangle and lock helpers
`timescale 1ns/1ps
`default_nettype none
interface fcc_link_if;
  logic [fcc_pkg::CODE_W-1:0] speed_code;
  logic [fcc_pkg::CODE_W-1:0] min_code;
  logic [fcc_pkg::CODE_W-1:0] tri_val;
  logic                       pwm_int;
  logic                       hall_pol;
  logic                       run_en;
  logic                       drive_en;
  logic                       locked;

  modport tri_gen (input speed_code, input min_code,
                   output tri_val, output pwm_int);
  modport lock (input hall_pol, input run_en,
                output drive_en, output locked);
  modport top (output speed_code, output min_code, output hall_pol,
               output run_en, input tri_val, input pwm_int,
               input drive_en, input locked);
endinterface
`default_nettype wire

// *** verilog/fcc_tri_pwm.sv ***
// triangle oscillator and comparator pwm for dc voltage speed control
`timescale 1ns/1ps
`default_nettype none
module fcc_tri_pwm
(
  input  wire logic clk,
  input  wire logic sys_rst,
  fcc_link_if.tri_gen lk
);
  logic [fcc_pkg::DIV_W-1:0]  div_r;
  logic [fcc_pkg::CODE_W-1:0] tri_r;
  logic                       up_r;
  logic                       pwm_r;

  // step divider, one enable pulse per triangle level
  always_ff @(posedge clk)
  begin
    if (sys_rst || div_r == fcc_pkg::TRI_DIV_LAST)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  // up and down ramp, turning at the ends
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tri_r <= fcc_pkg::TRI_BOT;
      up_r  <= 1'b1;
    end
    else if (div_r == fcc_pkg::TRI_DIV_LAST)
    begin
      if (up_r && tri_r == fcc_pkg::TRI_TOP - 8'h01)
        up_r <= 1'b0;
      else if (!up_r && tri_r == fcc_pkg::TRI_BOT + 8'h01)
        up_r <= 1'b1;
      tri_r <= up_r ? tri_r + 8'h01 : tri_r - 8'h01;
    end
  end

  // compare once per cycle, so pwm runs at triangle rate
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pwm_r <= 1'b0;
    else
      pwm_r <= (tri_r > lk.speed_code)   // speed setting
            || (tri_r > lk.min_code);    // minimum duty clamp
  end

  assign lk.tri_val = tri_r;
  assign lk.pwm_int = pwm_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_pwm_compare: assert property (
    (tri_r > lk.speed_code) |=> pwm_r)
    else $error("internal pwm low above speed setting");
  chk_min_clamp: assert property (
    (tri_r <= lk.speed_code && tri_r <= lk.min_code) |=> !pwm_r)
    else $error("internal pwm high with no cause");
  cov_clamp_on: cover property (
    (tri_r <= lk.speed_code) && (tri_r > lk.min_code));
endmodule // fcc_tri_pwm
`default_nettype wire

// *** verilog/fcc_lock_timer.sv ***
// rotor lock detection window and off time with retry
`timescale 1ns/1ps
`default_nettype none
module fcc_lock_timer
#(
  parameter int unsigned ON_CYC  = fcc_pkg::LOCK_ON_CYC,
  parameter int unsigned OFF_CYC = fcc_pkg::LOCK_OFF_CYC
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  fcc_link_if.lock  lk
);
  localparam logic [fcc_pkg::LCK_W-1:0] ON_LAST  =
    fcc_pkg::LCK_W'(ON_CYC - 1);
  localparam logic [fcc_pkg::LCK_W-1:0] OFF_LAST =
    fcc_pkg::LCK_W'(OFF_CYC - 1);

  fcc_pkg::fcc_lock_st_t       st_r;
  logic [fcc_pkg::LCK_W-1:0]   cnt_r;
  logic                        hall_d_r;
  logic                        hall_edge;

  assign hall_edge = lk.hall_pol != hall_d_r;

  // last hall level, for polarity change detection
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hall_d_r <= 1'b0;
    else
      hall_d_r <= lk.hall_pol;
  end

  // window, off time and retry sequencing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r  <= fcc_pkg::FCC_LK_RUN;
      cnt_r <= '0;
    end
    else
    begin
      unique case (st_r)
        fcc_pkg::FCC_LK_RUN, fcc_pkg::FCC_LK_RETRY:
        begin
          if (!lk.run_en)
            cnt_r <= '0;                  // idle drive, no lock check
          else if (hall_edge)
          begin
            cnt_r <= '0;
            st_r  <= fcc_pkg::FCC_LK_RUN; // rotation resumed
          end
          else if (cnt_r == ON_LAST)
          begin
            cnt_r <= '0;
            st_r  <= fcc_pkg::FCC_LK_OFF; // window gone, no edge
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        fcc_pkg::FCC_LK_OFF:
        begin
          if (cnt_r == OFF_LAST)
          begin
            cnt_r <= '0;
            st_r  <= fcc_pkg::FCC_LK_RETRY; // next attempt
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        default:
        begin
          cnt_r <= '0;
          st_r  <= fcc_pkg::FCC_LK_RUN;
        end
      endcase
    end
  end

  assign lk.drive_en = st_r != fcc_pkg::FCC_LK_OFF;
  assign lk.locked   = st_r != fcc_pkg::FCC_LK_RUN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_window_expiry: assert property (
    (st_r != fcc_pkg::FCC_LK_OFF && lk.run_en && !hall_edge
     && cnt_r == ON_LAST) |=> st_r == fcc_pkg::FCC_LK_OFF)
    else $error("lock window did not end in off time");
  chk_off_length: assert property (
    (st_r == fcc_pkg::FCC_LK_OFF && cnt_r == OFF_LAST)
    |=> st_r == fcc_pkg::FCC_LK_RETRY && cnt_r == '0)
    else $error("off time did not end in a retry");
  chk_edge_unlock: assert property (
    (st_r == fcc_pkg::FCC_LK_RETRY && lk.run_en && hall_edge)
    |=> !lk.locked && lk.drive_en)
    else $error("hall edge did not clear lock");
  cov_lock_retry: cover property (
    st_r == fcc_pkg::FCC_LK_OFF ##1 st_r == fcc_pkg::FCC_LK_RETRY);
endmodule // fcc_lock_timer
`default_nettype wire

// *** verilog/fcc_fan_ctrl.sv ***
// single coil fan commutation, speed pwm, standby and protection top
//
// Functional notes
// - long low pwm input enters standby
// - pwm input high leaves standby at once
// - external pwm gates hall-steered drive, else regenerate
// - dc mode uses internal pwm instead
// - tach pulled low while hall positive
// - lock state on separate open-drain output
// - drive enabled for lock detection window
// - drive held off in lock off time
// - external duty passes straight to drive
// - speed voltage compared with triangle wave
// - drive pwm at triangle frequency
// - minimum speed voltage clamps lowest duty
// - current sense trip cuts drive
// - thermal shutdown with hysteresis release
`timescale 1ns/1ps
`default_nettype none
module fcc_fan_ctrl
#(
  parameter int unsigned STANDBY_CYC  = fcc_pkg::STANDBY_CYC,
  parameter int unsigned LOCK_ON_CYC  = fcc_pkg::LOCK_ON_CYC,
  parameter int unsigned LOCK_OFF_CYC = fcc_pkg::LOCK_OFF_CYC
)
(
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       pwm_in,
  input  wire logic                       hall_in_pos,
  input  wire logic                       hall_in_neg,
  input  wire logic                       dc_mode_sel,
  input  wire logic [fcc_pkg::CODE_W-1:0] speed_voltage_in,
  input  wire logic [fcc_pkg::CODE_W-1:0] min_speed_voltage_in,
  input  wire logic                       current_sense_trip,
  input  wire logic                       temp_hot,
  input  wire logic                       temp_cooled,
  output logic                            coil_out_a,
  output logic                            coil_out_b,
  output logic                            tach_output_o,
  output logic                            tach_output_oe,
  output logic                            lock_status_o,
  output logic                            lock_status_oe,
  output logic                            standby,
  output logic                            current_limit_active,
  output logic                            thermal_shutdown
);
  localparam logic [fcc_pkg::SBY_W-1:0] SBY_LAST =
    fcc_pkg::SBY_W'(STANDBY_CYC - 1);
  localparam int unsigned NSYNC = 6 + 2 * fcc_pkg::CODE_W;

  fcc_link_if lk ();

  // two-stage synchronisers for every pin
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {pwm_in, hall_in_pos, hall_in_neg, dc_mode_sel,
                  current_sense_trip, temp_hot, speed_voltage_in,
                  min_speed_voltage_in};
      sync2_r <= sync1_r;
    end
  end

  logic                       pwm_s;
  logic                       pos_s;
  logic                       neg_s;
  logic                       dc_s;
  logic                       ilim_s;
  logic                       hot_s;
  logic [fcc_pkg::CODE_W-1:0] speed_s;
  logic [fcc_pkg::CODE_W-1:0] min_s;
  logic                       cool1_r;
  logic                       cool_s;

  assign {pwm_s, pos_s, neg_s, dc_s, ilim_s, hot_s, speed_s, min_s} =
    sync2_r;

  // release comparator synchronised on its own pair
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cool1_r <= 1'b0;
      cool_s  <= 1'b0;
    end
    else
    begin
      cool1_r <= temp_cooled;
      cool_s  <= cool1_r;
    end
  end

  // hall polarity decode
  logic hall_a;
  logic hall_b;
  assign hall_a = pos_s && !neg_s;
  assign hall_b = neg_s && !pos_s;

  // standby: count low time of the pwm pin
  logic [fcc_pkg::SBY_W-1:0] sby_cnt_r;
  logic                      standby_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sby_cnt_r <= '0;
      standby_r <= 1'b0;
    end
    else if (pwm_s)
    begin
      sby_cnt_r <= '0;
      standby_r <= 1'b0;                // wake on high level
    end
    else if (sby_cnt_r == SBY_LAST)
      standby_r <= 1'b1;                // low too long
    else
      sby_cnt_r <= sby_cnt_r + 1'b1;
  end

  // thermal shutdown, set wins over the cooled release
  logic tsd_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tsd_r <= 1'b0;
    else if (hot_s)
      tsd_r <= 1'b1;
    else if (cool_s)
      tsd_r <= 1'b0;
  end

  // helper hookup
  assign lk.speed_code = speed_s;
  assign lk.min_code   = min_s;
  assign lk.hall_pol   = pos_s;
  assign lk.run_en     = !standby_r && !tsd_r;

  fcc_tri_pwm u_tri (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lk      (lk.tri_gen)
  );

  fcc_lock_timer #(
    .ON_CYC  (LOCK_ON_CYC),
    .OFF_CYC (LOCK_OFF_CYC)
  ) u_lock (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lk      (lk.lock)
  );

  // speed gate: pin duty or internal comparator pwm
  logic gate;
  logic drive_ok;
  assign gate = dc_s ? lk.pwm_int
                     : pwm_s;
  assign drive_ok = gate && !standby_r && !tsd_r && lk.drive_en
                 && !ilim_s;

  // coil bridge outputs, both low is regenerate
  logic coil_a_r;
  logic coil_b_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      coil_a_r <= 1'b0;
      coil_b_r <= 1'b0;
    end
    else
    begin
      coil_a_r <= drive_ok && hall_a;
      coil_b_r <= drive_ok && hall_b;
    end
  end

  // open-drain tach and lock pins, plus status flags
  logic tach_oe_r;
  logic lock_oe_r;
  logic ilim_r;
  logic od_low_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tach_oe_r <= 1'b0;
      lock_oe_r <= 1'b0;
      ilim_r    <= 1'b0;
      od_low_r  <= 1'b0;
    end
    else
    begin
      tach_oe_r <= hall_a;              // follows hall
      lock_oe_r <= lk.locked;           // pulled low when locked
      ilim_r    <= ilim_s;
      od_low_r  <= 1'b0;
    end
  end

  assign coil_out_a           = coil_a_r;
  assign coil_out_b           = coil_b_r;
  assign tach_output_o        = od_low_r;
  assign tach_output_oe       = tach_oe_r;
  assign lock_status_o        = od_low_r;
  assign lock_status_oe       = lock_oe_r;
  assign standby              = standby_r;
  assign current_limit_active = ilim_r;
  assign thermal_shutdown     = tsd_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_standby_entry: assert property (
    (!pwm_s && sby_cnt_r == SBY_LAST) |=> standby_r)
    else $error("standby not entered after low delay");
  chk_standby_early: assert property (
    (!pwm_s && !standby_r && sby_cnt_r != SBY_LAST) |=> !standby_r)
    else $error("standby entered before delay elapsed");
  chk_standby_exit: assert property (
    pwm_s |=> !standby_r && !standby)
    else $error("standby held while pwm high");
  chk_ext_drive_a: assert property (
    (!dc_s && pwm_s && hall_a && !standby_r && !tsd_r
     && lk.drive_en && !ilim_s) |=> coil_out_a && !coil_out_b)
    else $error("external pwm drive a phase wrong");
  chk_dc_drive_b: assert property (
    (dc_s && lk.pwm_int && hall_b && !standby_r && !tsd_r
     && lk.drive_en && !ilim_s) |=> coil_out_b && !coil_out_a)
    else $error("internal pwm drive b phase wrong");
  chk_regen_low: assert property (
    !gate |=> !coil_out_a && !coil_out_b)
    else $error("drive present with speed gate low");
  chk_tach_follow: assert property (
    hall_a |=> tach_output_oe && !tach_output_o)
    else $error("tach not pulled low with hall positive");
  chk_tach_release: assert property (
    hall_b |=> !tach_output_oe)
    else $error("tach driven with hall negative");
  chk_lock_pin: assert property (
    lk.locked |=> lock_status_oe && !lock_status_o)
    else $error("lock state not on lock pin");
  chk_lock_off_drive: assert property (
    !lk.drive_en |=> !coil_out_a && !coil_out_b)
    else $error("coil driven during lock off time");
  chk_current_limit: assert property (
    ilim_s |=> !coil_out_a && !coil_out_b && current_limit_active)
    else $error("drive not cut on current trip");
  chk_thermal_hold: assert property (
    (tsd_r && !cool_s) |=> thermal_shutdown ##0 !coil_out_a [*2])
    else $error("thermal shutdown released early");
  chk_thermal_set: assert property (
    $rose(hot_s) |=> thermal_shutdown)
    else $error("thermal shutdown not set");
  chk_hot_wins: assert property (
    (hot_s && cool_s) |=> thermal_shutdown)
    else $error("cooled release beat the hot flag");

  // pin checks for held hall levels, standby, lock and current limit release
  chk_tach_equal: assert property (
    (pos_s == neg_s) |=> !tach_output_oe)
    else $error("tach driven with equal hall inputs");
  chk_standby_drive: assert property (
    standby_r |=> !coil_out_a && !coil_out_b)
    else $error("coil driven in standby");
  chk_lock_release: assert property (
    !lk.locked |=> !lock_status_oe)
    else $error("lock pin held after rotation resumed");
  chk_ilim_release: assert property (
    !ilim_s |=> !current_limit_active)
    else $error("current limit flag stuck");

  // dc mode regenerate while triangle is under both codes
  chk_dc_regen: assert property (
    (dc_s && lk.tri_val <= speed_s && lk.tri_val <= min_s) ##1 dc_s
    |=> !coil_out_a && !coil_out_b)
    else $error("drive present with internal pwm low");


  cov_standby_cycle: cover property (
    standby_r ##1 pwm_s ##1 !standby_r);
  cov_ext_both_phases: cover property (
    coil_out_a ##[1:1000] coil_out_b);
  cov_dc_drive: cover property (dc_s && coil_out_a);
  cov_thermal_release: cover property (tsd_r ##1 !tsd_r);
endmodule // fcc_fan_ctrl
`default_nettype wire

// *** tb/fcc_host_model.sv ***
// host pwm source and hall sensor model for the fan control bench
`timescale 1ns/1ps
`default_nettype none
module fcc_host_model
(
  input  wire logic        clk,
  input  wire logic [15:0] pwm_period,
  input  wire logic [15:0] pwm_high,
  input  wire logic [15:0] hall_half,
  input  wire logic        hold_pos,
  input  wire logic        hold_neg,
  output logic             pwm_in,
  output logic             hall_in_pos,
  output logic             hall_in_neg
);
  logic [15:0] pwm_cnt_r  = 16'h0000;
  logic [15:0] hall_cnt_r = 16'h0000;
  logic        pwm_r      = 1'b0;
  logic        pos_r      = 1'b0;
  logic        neg_r      = 1'b1;

  // pwm pin high for pwm_high of every pwm_period cycles
  // low for the remaining cycles, held low throughout when pwm_high is zero
  always_ff @(posedge clk)
  begin
    if (pwm_cnt_r + 16'h0001 >= pwm_period)
      pwm_cnt_r <= 16'h0000;
    else
      pwm_cnt_r <= pwm_cnt_r + 16'h0001;
    pwm_r <= (pwm_cnt_r < pwm_high);
  end

  // hall sensor: held levels, or complementary toggle every hall_half
  always_ff @(posedge clk)
  begin
    if (hall_half == 16'h0000)
    begin
      hall_cnt_r <= 16'h0000;
      pos_r      <= hold_pos;
      neg_r      <= hold_neg;
    end
    else if (hall_cnt_r + 16'h0001 >= hall_half)
    begin
      hall_cnt_r <= 16'h0000;
      pos_r      <= ~pos_r;
      neg_r      <= pos_r;
    end
    else
      hall_cnt_r <= hall_cnt_r + 16'h0001;
  end

  // pin levels
  assign pwm_in      = pwm_r;
  assign hall_in_pos = pos_r;
  assign hall_in_neg = neg_r;
endmodule // fcc_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the fan commutation control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SBY  = 600;
  localparam int LON  = 500;
  localparam int LOFF = 4500;
  localparam int DIV  = int'(fcc_pkg::TRI_DIV);
  localparam int PER  = 2 * (int'(fcc_pkg::TRI_STEPS) - 1) * DIV;

  typedef struct packed {
    logic [3:0] ctl;   // pwm, hall pos, hall neg, dc mode
    logic [7:0] spd;
    logic [7:0] mn;
    logic [2:0] prot;  // trip, hot, cooled
    logic [4:0] exp;   // coil a, coil b, tach oe, limit, thermal
  } fcc_row_t;

  logic                       clk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       dc_mode_sel = 1'b0;
  logic [fcc_pkg::CODE_W-1:0] speed_voltage_in = 8'hff;
  logic [fcc_pkg::CODE_W-1:0] min_speed_voltage_in = 8'hff;
  logic                       current_sense_trip = 1'b0;
  logic                       temp_hot = 1'b0;
  logic                       temp_cooled = 1'b0;
  logic [15:0]                pwm_period = 16'd400;
  logic [15:0]                pwm_high = 16'hffff;
  logic [15:0]                hall_half = 16'h0000;
  logic                       hold_pos = 1'b1;
  logic                       hold_neg = 1'b0;
  logic                       pwm_in, hall_in_pos, hall_in_neg;
  logic                       coil_out_a, coil_out_b, standby;
  logic                       tach_output_o, tach_output_oe;
  logic                       lock_status_o, lock_status_oe;
  logic                       current_limit_active, thermal_shutdown;
  wire logic [4:0]            outs;
  wire logic [3:0]            side;
  int                         err_count = 0;
  int                         cmp_count = 0;
  int                         n, on, rises;

  fcc_row_t rows [13] = '{
    '{4'hc, 8'hff, 8'hff, 3'h0, 5'h14}, // drive a
    '{4'ha, 8'hff, 8'hff, 3'h0, 5'h08}, // drive b
    '{4'h4, 8'hff, 8'hff, 3'h0, 5'h04}, // regenerate
    '{4'h2, 8'hff, 8'hff, 3'h0, 5'h00}, // regenerate
    '{4'h8, 8'hff, 8'hff, 3'h0, 5'h00}, // hall both low
    '{4'he, 8'hff, 8'hff, 3'h0, 5'h00}, // hall both high
    '{4'hd, 8'hff, 8'hff, 3'h0, 5'h04}, // dc, no duty
    '{4'hc, 8'hff, 8'hff, 3'h4, 5'h06}, // current trip
    '{4'ha, 8'hff, 8'hff, 3'h2, 5'h01}, // hot
    '{4'hc, 8'hff, 8'hff, 3'h0, 5'h05}, // still shut
    '{4'ha, 8'hff, 8'hff, 3'h1, 5'h08}, // cooled
    '{4'hc, 8'hff, 8'hff, 3'h3, 5'h05}, // hot wins
    '{4'ha, 8'hff, 8'hff, 3'h1, 5'h08}  // cooled
  };

  assign outs = {coil_out_a, coil_out_b, tach_output_oe,
                 current_limit_active, thermal_shutdown};
  assign side = {tach_output_o, lock_status_o, lock_status_oe, standby};

  fcc_fan_ctrl #(.STANDBY_CYC(SBY), .LOCK_ON_CYC(LON), .LOCK_OFF_CYC(LOFF))
  fcc_fan_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .pwm_in(pwm_in),
    .hall_in_pos(hall_in_pos), .hall_in_neg(hall_in_neg),
    .dc_mode_sel(dc_mode_sel), .speed_voltage_in(speed_voltage_in),
    .min_speed_voltage_in(min_speed_voltage_in),
    .current_sense_trip(current_sense_trip), .temp_hot(temp_hot),
    .temp_cooled(temp_cooled), .coil_out_a(coil_out_a),
    .coil_out_b(coil_out_b), .tach_output_o(tach_output_o),
    .tach_output_oe(tach_output_oe), .lock_status_o(lock_status_o),
    .lock_status_oe(lock_status_oe), .standby(standby),
    .current_limit_active(current_limit_active),
    .thermal_shutdown(thermal_shutdown));

  fcc_host_model fcc_host_model_inst (.clk(clk), .pwm_period(pwm_period),
    .pwm_high(pwm_high), .hall_half(hall_half), .hold_pos(hold_pos),
    .hold_neg(hold_neg), .pwm_in(pwm_in), .hall_in_pos(hall_in_pos),
    .hall_in_neg(hall_in_neg));

  // clock, 25 ns period
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // compare of level results
  task automatic chk_bit(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // compare of counted cycles against a window
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // pin levels of one row, pwm duty given apart
  task automatic drive_row(input fcc_row_t r, input logic [15:0] hi);
    pwm_high             <= hi;
    hold_pos             <= r.ctl[2];
    hold_neg             <= r.ctl[1];
    dc_mode_sel          <= r.ctl[0];
    speed_voltage_in     <= r.spd;
    min_speed_voltage_in <= r.mn;
    {current_sense_trip, temp_hot, temp_cooled} <= r.prot;
  endtask

  // bounded wait for a level, edges counted
  task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // drive cycles and drive starts over a window
  task automatic count_drive(input int len);
    logic prev;
    logic cur;
    on = 0;
    rises = 0;
    prev = 1'b1;
    repeat (len)
    begin
      @(posedge clk);
      #1;
      cur = ((coil_out_a | coil_out_b) === 1'b1);
      on += int'(cur);
      rises += int'(cur && !prev);
      prev = cur;
    end
  endtask

  // counts, verdict and end of run
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    print_verdict();
  end

  // main sequence
  initial
  begin
    repeat (9) @(posedge clk);
    #1;
    chk_bit({3'h0, outs}, 8'h00);
    @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      @(posedge clk);
      drive_row(rows[i], rows[i].ctl[3] ? 16'hffff : 16'h0000);
      repeat (5) @(posedge clk);
      #1;
      chk_bit({3'h0, outs}, {3'h0, rows[i].exp});
      chk_bit({4'h0, side}, 8'h00);
      $display("row %0d done", i);
    end
    // dc mode duty and frequency, pwm pin held high
    @(posedge clk);
    hall_half <= 16'd100;
    drive_row('{4'h9, 8'h80, 8'hff, 3'h0, 5'h00}, 16'hffff);
    repeat (PER) @(posedge clk);
    count_drive(4 * PER);
    chk_rng(on, 4 * DIV * 253 - 4, 4 * DIV * 253 + 4);
    chk_rng(rises, 4, 4);
    @(posedge clk);
    drive_row('{4'h9, 8'hff, 8'hc0, 3'h0, 5'h00}, 16'hffff);
    repeat (PER) @(posedge clk);
    count_drive(4 * PER);
    chk_rng(on, 4 * DIV * 125 - 4, 4 * DIV * 125 + 4);
    $display("dc duty done");
    // external duty 100 of 400 cycles
    @(posedge clk);
    drive_row('{4'h8, 8'hff, 8'hff, 3'h0, 5'h00}, 16'd100);
    repeat (400) @(posedge clk);
    count_drive(4000);
    chk_rng(on, 992, 1008);
    chk_rng(rises, 10, 10);
    chk_bit({7'h0, standby}, 8'h00);
    $display("ext duty done");
    // lock: hall frozen after a known change
    @(posedge clk);
    hall_half <= 16'h0000;
    drive_row('{4'ha, 8'hff, 8'hff, 3'h0, 5'h00}, 16'hffff);
    repeat (10) @(posedge clk);
    drive_row('{4'hc, 8'hff, 8'hff, 3'h0, 5'h00}, 16'hffff);
    wait_lvl(lock_status_oe, 1'b1, 2000);
    chk_rng(n, LON, LON + 10);
    repeat (2) @(posedge clk);
    #1;
    chk_bit({3'h0, outs}, 8'h04);
    chk_bit({4'h0, side}, 8'h02);
    wait_lvl(coil_out_a, 1'b1, 6000);
    chk_rng(n, LOFF - 8, LOFF + 6);
    chk_bit({7'h0, lock_status_oe}, 8'h01);
    @(posedge clk);
    hall_half <= 16'd100;
    wait_lvl(lock_status_oe, 1'b0, 2000);
    chk_rng(n, 1, LON);
    $display("lock done");
    // standby entry and exit
    @(posedge clk);
    pwm_high <= 16'h0000;
    wait_lvl(standby, 1'b1, 2000);
    chk_rng(n, SBY, SBY + 8);
    chk_bit({6'h0, coil_out_a, coil_out_b}, 8'h00);
    @(posedge clk);
    pwm_high <= 16'hffff;
    wait_lvl(standby, 1'b0, 20);
    chk_rng(n, 1, 6);
    $display("standby done");
    // reset in mid-run with drive active
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_bit({3'h0, outs}, 8'h00);
    chk_bit({4'h0, side}, 8'h00);
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit({3'h0, outs}, 8'h00);
    $display("reset done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
